// File: bench/pio_pin_partner.sv
// partner: external circuitry on the port pins
`timescale 1ns/1ns
// ==========
// pin levels
module pio_pin_partner (
    input wire logic [pio_pkg::PIO_NPINS-1:0] i_pin_out,
    input wire logic [pio_pkg::PIO_NPINS-1:0] i_pin_oe,
    input wire logic [pio_pkg::PIO_NPINS-1:0] i_pull_en,
    input wire logic [pio_pkg::PIO_NPINS-1:0] i_ext,
    input wire logic [pio_pkg::PIO_NPINS-1:0] i_ext_en,
    output logic [pio_pkg::PIO_NPINS-1:0] o_pin
);
    import pio_pkg::*;
    // floating pins show 1 when pulled, else the inverse of i_pin_out so a stale value never passes
    assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_en & i_ext)
        | (~i_pin_oe & ~i_ext_en & (i_pull_en | ~i_pin_out));
endmodule

// File: bench/pio_ports_asserts.sv
// checker: port-level properties of the programmable io block
`timescale 1ns/1ns
// ==========
// properties
module pio_ports_asserts (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic [2:0] i_rd_sel,
    input wire logic [3:0] i_rd_port,
    input wire logic i_bus_mode,
    input wire logic [pio_pkg::PIO_NPINS-1:0] i_bus_pin_mask,
    input wire logic [pio_pkg::PIO_NPINS-1:0] i_periph_oe,
    input wire logic [pio_pkg::PIO_NPINS-1:0] i_periph_out,
    input wire logic [pio_pkg::PIO_NPINS-1:0] o_pin_out,
    input wire logic [pio_pkg::PIO_NPINS-1:0] o_pin_oe,
    input wire logic [pio_pkg::PIO_NPINS-1:0] o_pull_en,
    input wire logic o_bclk_oe,
    input wire logic [7:0] o_rd_data
);
    import pio_pkg::*;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    localparam logic [87:0] only_pin = 88'h1 << PIO_INPUT_ONLY_IDX;
    // ports 0-3, port four low half, port five
    localparam logic [87:0] dead_pins = 88'hff0fffffffff;
    // three cycles cover the write-to-pin pipeline
    sequence locked;
        (i_bus_mode && i_periph_oe == '0 && $stable(i_bus_pin_mask))[*3];
    endsequence
    a_only_never_out: assert property (((o_pin_oe | o_pull_en) & only_pin) == '0)
        else $error("input-only pin driven or pulled");
    a_only_no_dir: assert property (i_rd_sel == PIO_SEL_DIR && i_rd_port == 4'h8 |=> !o_rd_data[5])
        else $error("input-only pin has a direction bit");
    a_periph_drives: assert property (i_periph_oe[0] |=> o_pin_oe[0] && o_pin_out[0] == $past(i_periph_out[0]))
        else $error("peripheral output not driven");
    a_dir_locked: assert property (locked |-> ((o_pin_oe ^ $past(o_pin_oe)) & i_bus_pin_mask) == '0)
        else $error("bus pin direction changed");
    a_data_locked: assert property (locked |-> ((o_pin_out ^ $past(o_pin_out)) & i_bus_pin_mask) == '0)
        else $error("bus pin latch changed");
    a_pull_only_in: assert property ((o_pull_en & o_pin_oe) == '0)
        else $error("pull-up on an output pin");
    a_bus_pull_dead: assert property ($past(i_bus_mode) |-> (o_pull_en & dead_pins) == '0)
        else $error("dead pull-up connected in bus mode");
    a_bclk_needs_bus: assert property (o_bclk_oe |-> $past(i_bus_mode))
        else $error("bus clock driven outside bus mode");
    a_reset_all_in: assert property (disable iff (1'b0) !i_resetn |-> o_pin_oe == '0 && o_pull_en == '0)
        else $error("pin driven during reset");
    c_locked: cover property (locked);
    c_periph: cover property (i_periph_oe[0]);
    c_bclk: cover property (o_bclk_oe);
endmodule

bind pio_ports pio_ports_asserts chk (.*);

// File: bench/test_programmable_io_ports.sv
// testbench: directed checks of the programmable io port block
`timescale 1ns/1ns
module test_programmable_io_ports;
    import pio_pkg::*;
    // ==========
    // signals
    logic i_ref_clk = 1'b0, i_resetn = 1'b0, i_wr_en = 1'b0, i_bus_mode = 1'b0, i_bus_8bit = 1'b0;
    logic i_port_one_free = 1'b0, i_bclk = 1'b0, o_bclk_out, o_bclk_oe;
    logic [2:0] i_wr_sel = 3'h0, i_rd_sel = 3'h0;
    logic [3:0] i_wr_port = 4'h0, i_rd_port = 4'h0;
    logic [7:0] i_wr_data = 8'h00, o_rd_data;
    logic [87:0] i_bus_pin_mask = '0, i_periph_oe = '0, i_periph_out = '0, ext = '0, ext_en = '0;
    logic [87:0] i_pin_in, o_pin_out, o_pin_oe, o_pull_en;
    int num_errors = 0, total_checks = 0;
    always #4 i_ref_clk = ~i_ref_clk;
    always @(negedge i_ref_clk) i_bclk <= ~i_bclk;
    pio_ports dut (.*);
    pio_pin_partner ext_side (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_pull_en(o_pull_en),
        .i_ext(ext), .i_ext_en(ext_en), .o_pin(i_pin_in));
    // ==========
    // tasks
    task automatic chk(input logic [87:0] got, input logic [87:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] s, input logic [3:0] p, input logic [7:0] d);
        @(negedge i_ref_clk);
        i_wr_en = 1'b1;
        i_wr_sel = s;
        i_wr_port = p;
        i_wr_data = d;
        @(negedge i_ref_clk);
        i_wr_en = 1'b0;
    endtask
    // read data lags the select by one edge
    task automatic rd(input logic [2:0] s, input logic [3:0] p, input logic [7:0] e);
        @(negedge i_ref_clk);
        i_rd_sel = s;
        i_rd_port = p;
        @(negedge i_ref_clk);
        chk({80'h0, o_rd_data}, {80'h0, e});
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ==========
    // sequence
    initial begin
        repeat (5) @(negedge i_ref_clk);
        i_resetn = 1'b1;
        rd(PIO_SEL_DIR, 4'h0, 8'h00);
        chk(o_pin_oe, '0);
        wr(PIO_SEL_DIR, 4'h2, 8'hff);
        wr(PIO_SEL_DATA, 4'h2, 8'ha5);
        repeat (2) @(negedge i_ref_clk);
        chk(o_pin_oe, 88'hff << 16);
        chk(o_pin_out & (88'hff << 16), 88'ha5 << 16);
        rd(PIO_SEL_DATA, 4'h2, 8'ha5);
        ext = 88'h5a << 32;
        ext_en = 88'hff << 32;
        wr(PIO_SEL_PULL, 4'h3, 8'h03);
        wr(PIO_SEL_DIR, 4'h3, 8'h0f);
        repeat (3) @(negedge i_ref_clk);
        chk(o_pull_en, 88'hf0 << 24);
        rd(PIO_SEL_DATA, 4'h4, 8'h5a);
        rd(PIO_SEL_DATA, 4'h3, 8'hf0);
        wr(PIO_SEL_DIR, 4'h8, 8'hff);
        rd(PIO_SEL_DIR, 4'h8, 8'hdf);
        chk(o_pin_oe & (88'hff << 64), 88'hdf << 64);
        // direction stays input before the peripheral takes the pin
        wr(PIO_SEL_PULL, 4'h0, 8'h01);
        i_periph_out = 88'h1;
        i_periph_oe = 88'h1;
        repeat (2) @(negedge i_ref_clk);
        chk(o_pin_oe & 88'hf, 88'h1);
        chk(o_pull_en & 88'hf, 88'he);
        i_periph_oe = '0;
        // chip-select and converter pins are never set to output here
        i_bus_mode = 1'b1;
        i_bus_pin_mask = 88'hff;
        wr(PIO_SEL_DIR, 4'h0, 8'hff);
        wr(PIO_SEL_DATA, 4'h0, 8'hff);
        rd(PIO_SEL_DIR, 4'h0, 8'h00);
        chk(o_pin_out & 88'hff, '0);
        rd(PIO_SEL_PULL, 4'h0, 8'h01);
        chk(o_pull_en & 88'hff, '0);
        chk({87'h0, o_bclk_oe}, 88'h1);
        chk({87'h0, o_bclk_out}, {87'h0, i_bclk});
        wr(PIO_SEL_PMODE, 4'h0, 8'h80);
        repeat (2) @(negedge i_ref_clk);
        chk({87'h0, o_bclk_oe}, '0);
        ext = 88'hc3 << 8;
        ext_en = 88'hff << 8;
        wr(PIO_SEL_DATA, 4'h1, 8'h3c);
        wr(PIO_SEL_CTRL, 4'h0, 8'h01);
        rd(PIO_SEL_DATA, 4'h1, 8'hc3);
        i_bus_8bit = 1'b1;
        rd(PIO_SEL_DATA, 4'h1, 8'h3c);
        wr(PIO_SEL_CTRL, 4'h0, 8'h00);
        rd(PIO_SEL_DATA, 4'h1, 8'hc3);
        wr(PIO_SEL_CTRL, 4'h0, 8'h01);
        i_bus_8bit = 1'b0;
        i_port_one_free = 1'b1;
        rd(PIO_SEL_DATA, 4'h1, 8'h3c);
        summarize();
    end
endmodule

// File: hdl/pio_pkg.sv
// package: constants for the programmable io port block
package pio_pkg;
    localparam int PIO_NPORTS = 11;
    localparam int PIO_NPINS = 88;
    localparam int PIO_NGROUPS = 22;
    localparam int PIO_GROUP_W = 4;
    localparam int PIO_INPUT_ONLY_IDX = 69;
    localparam int PIO_PORT_ONE = 1;
    // register selects on the write and read ports
    localparam logic [2:0] PIO_SEL_DIR = 3'h0;
    localparam logic [2:0] PIO_SEL_DATA = 3'h1;
    localparam logic [2:0] PIO_SEL_PULL = 3'h2;
    localparam logic [2:0] PIO_SEL_CTRL = 3'h3;
    localparam logic [2:0] PIO_SEL_PMODE = 3'h4;
    // field positions
    localparam int PIO_READ_SRC_BIT = 0;
    localparam int PIO_BCLK_DIS_BIT = 7;
    // pull-up groups whose resistor is dead in the bus modes
    localparam logic [21:0] PIO_PULL_BUS_DEAD = 22'h000dff;
    // values after reset
    localparam logic [87:0] PIO_DIR_RESET = 88'h0;
    localparam logic [87:0] PIO_DATA_RESET = 88'h0;
    localparam logic [21:0] PIO_PULL_RESET = 22'h0;
    localparam logic [7:0] PIO_BYTE_RESET = 8'h00;
endpackage

// File: hdl/pio_ports.sv
// module: programmable io port logic, direction, latches, pull-ups, read-back
`timescale 1ns/1ns

module pio_ports (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_wr_en,
    input wire logic [2:0] i_wr_sel,
    input wire logic [3:0] i_wr_port,
    input wire logic [7:0] i_wr_data,
    input wire logic [2:0] i_rd_sel,
    input wire logic [3:0] i_rd_port,
    input wire logic i_bus_mode,
    input wire logic i_bus_8bit,
    input wire logic i_port_one_free,
    input wire logic [pio_pkg::PIO_NPINS-1:0] i_bus_pin_mask,
    input wire logic [pio_pkg::PIO_NPINS-1:0] i_periph_oe,
    input wire logic [pio_pkg::PIO_NPINS-1:0] i_periph_out,
    input wire logic i_bclk,
    input wire logic [pio_pkg::PIO_NPINS-1:0] i_pin_in,
    output logic [pio_pkg::PIO_NPINS-1:0] o_pin_out,
    output logic [pio_pkg::PIO_NPINS-1:0] o_pin_oe,
    output logic [pio_pkg::PIO_NPINS-1:0] o_pull_en,
    output logic o_bclk_out,
    output logic o_bclk_oe,
    output logic [7:0] o_rd_data
);
    import pio_pkg::*;

    // ==========================================================
    // state
    logic [PIO_NPINS-1:0] dir;
    logic [PIO_NPINS-1:0] latch;
    logic [PIO_NGROUPS-1:0] pull;
    logic [7:0] port_ctrl;
    logic [7:0] pmode;
    logic [PIO_NPINS-1:0] pin_meta;
    logic [PIO_NPINS-1:0] pin_sync;
    logic [PIO_NPINS-1:0] lock;
    logic [PIO_NPINS-1:0] next_pull_en;
    logic [7:0] next_rd_data;
    logic read_src_live;
    logic wr_dir;
    logic wr_data;
    logic wr_pull;
    logic wr_ctrl;
    logic wr_pmode;
    logic [PIO_NPINS-1:0] pin_is_input;
    logic [PIO_NPINS-1:0] next_pin_oe;
    logic [PIO_NPINS-1:0] next_pin_out;
    logic [PIO_NGROUPS-1:0] group_live;

    // port numbers above the last port select nothing
    function automatic logic pio_port_ok(input logic [3:0] port);
        return int'(port) < PIO_NPORTS;
    endfunction

    // one port byte as read: latch while driving, synchronised level otherwise
    function automatic logic [7:0] pio_read_byte(input logic [PIO_NPINS-1:0] d,
                                                 input logic [PIO_NPINS-1:0] lt,
                                                 input logic [PIO_NPINS-1:0] pin,
                                                 input logic [3:0] port);
        logic [7:0] r;
        r = 8'h00;
        for (int b = 0; b < 8; b++) begin
            if (d[int'(port) * 8 + b]) begin
                r[b] = lt[int'(port) * 8 + b];
            end else begin
                r[b] = pin[int'(port) * 8 + b];
            end
        end
        return r;
    endfunction

    // merge a byte write, keeping bits that are locked
    function automatic logic [PIO_NPINS-1:0] pio_merge(input logic [PIO_NPINS-1:0] old,
                                                       input logic [PIO_NPINS-1:0] lk,
                                                       input logic [3:0] port,
                                                       input logic [7:0] wdata);
        logic [PIO_NPINS-1:0] r;
        r = old;
        for (int b = 0; b < 8; b++) begin
            if (!lk[int'(port) * 8 + b]) begin
                r[int'(port) * 8 + b] = wdata[b];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // pin synchroniser, pins are outside our clock domain
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_meta <= PIO_DATA_RESET;
            pin_sync <= PIO_DATA_RESET;
        end else begin
            pin_meta <= i_pin_in;
            pin_sync <= pin_meta;
        end
    end

    // bus lines are frozen only in the bus modes
    assign lock = i_bus_mode ? i_bus_pin_mask : '0;

    // ==========================================================
    // write strobes, one per register kind
    always_comb begin
        wr_dir = 1'b0;
        wr_data = 1'b0;
        wr_pull = 1'b0;
        wr_ctrl = 1'b0;
        wr_pmode = 1'b0;
        if (i_wr_en) begin
            case (i_wr_sel)
                PIO_SEL_DIR: wr_dir = pio_port_ok(i_wr_port);
                PIO_SEL_DATA: wr_data = pio_port_ok(i_wr_port);
                PIO_SEL_PULL: wr_pull = pio_port_ok(i_wr_port);
                PIO_SEL_CTRL: wr_ctrl = 1'b1;
                PIO_SEL_PMODE: wr_pmode = 1'b1;
                default: wr_dir = 1'b0;
            endcase
        end
    end

    // ==========================================================
    // software writes
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dir <= PIO_DIR_RESET;
        end else if (wr_dir) begin
            dir <= pio_merge(dir, lock, i_wr_port, i_wr_data);
            dir[PIO_INPUT_ONLY_IDX] <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            latch <= PIO_DATA_RESET;
        end else if (wr_data) begin
            latch <= pio_merge(latch, lock, i_wr_port, i_wr_data);
        end
    end

    // pull-up enables packed two groups per port byte, always writable
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pull <= PIO_PULL_RESET;
        end else if (wr_pull) begin
            pull[int'(i_wr_port) * 2 +: 2] <= i_wr_data[1:0];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            port_ctrl <= PIO_BYTE_RESET;
        end else if (wr_ctrl) begin
            port_ctrl <= {7'h00, i_wr_data[PIO_READ_SRC_BIT]};
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pmode <= PIO_BYTE_RESET;
        end else if (wr_pmode) begin
            pmode <= {i_wr_data[PIO_BCLK_DIS_BIT], 7'h00};
        end
    end

    // ==========================================================
    // pin drive and pull-up
    // a dead group keeps its bit but never reaches the resistor while i_bus_mode is set
    always_comb begin
        group_live = '0;
        for (int g = 0; g < PIO_NGROUPS; g++) begin
            group_live[g] = pull[g] && !(i_bus_mode && PIO_PULL_BUS_DEAD[g]);
        end
    end

    // a peripheral driving the pin counts as output for the pull-up too
    assign pin_is_input = ~(dir | i_periph_oe);

    // converter output never arrives on i_periph_oe, its pin stays under dir
    assign next_pin_oe = (i_periph_oe | dir) & ~(88'h1 << PIO_INPUT_ONLY_IDX);
    assign next_pin_out = (i_periph_oe & i_periph_out) | (~i_periph_oe & latch);

    always_comb begin
        next_pull_en = '0;
        for (int i = 0; i < PIO_NPINS; i++) begin
            next_pull_en[i] = group_live[i / PIO_GROUP_W] && pin_is_input[i];
        end
        next_pull_en[PIO_INPUT_ONLY_IDX] = 1'b0;
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pin_oe <= PIO_DIR_RESET;
        end else begin
            o_pin_oe <= next_pin_oe;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pin_out <= PIO_DATA_RESET;
        end else begin
            o_pin_out <= next_pin_out;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pull_en <= PIO_DIR_RESET;
        end else begin
            o_pull_en <= next_pull_en;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_bclk_out <= 1'b0;
            o_bclk_oe <= 1'b0;
        end else begin
            o_bclk_out <= i_bclk;
            o_bclk_oe <= i_bus_mode && !pmode[PIO_BCLK_DIS_BIT];
        end
    end

    // ==========================================================
    // read-back
    assign read_src_live = (i_bus_mode && i_bus_8bit) || i_port_one_free;

    always_comb begin
        next_rd_data = 8'h00;
        case (i_rd_sel)
            PIO_SEL_DIR: begin
                if (int'(i_rd_port) < PIO_NPORTS) begin
                    next_rd_data = dir[int'(i_rd_port) * 8 +: 8];
                end
            end
            PIO_SEL_DATA: begin
                if (int'(i_rd_port) < PIO_NPORTS) begin
                    next_rd_data = pio_read_byte(dir, latch, pin_sync, i_rd_port);
                    if (int'(i_rd_port) == PIO_PORT_ONE && read_src_live && port_ctrl[PIO_READ_SRC_BIT]) begin
                        next_rd_data = latch[PIO_PORT_ONE * 8 +: 8];
                    end
                end
            end
            PIO_SEL_PULL: begin
                if (int'(i_rd_port) < PIO_NPORTS) begin
                    next_rd_data = {6'h00, pull[int'(i_rd_port) * 2 +: 2]};
                end
            end
            PIO_SEL_CTRL: next_rd_data = port_ctrl;
            PIO_SEL_PMODE: next_rd_data = pmode;
            default: next_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rd_data <= PIO_BYTE_RESET;
        end else begin
            o_rd_data <= next_rd_data;
        end
    end
endmodule
